// file: design/capture_compare_timer16_regs.vh
// Register map, field positions and reset values of the 16-bit timer
`ifndef CAPTURE_COMPARE_TIMER16_REGS_VH
`define CAPTURE_COMPARE_TIMER16_REGS_VH
// ****************************************
// Byte offsets on the APB
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_COUNT       8'h04
`define OFS_IRQ_STATUS  8'h08
`define OFS_IRQ_MASK    8'h0c
`define OFS_VECTOR      8'h10
`define OFS_CCTL_BASE   8'h20
`define OFS_CCR_BASE    8'h40
// ****************************************
// Control register fields
// ****************************************
`define CTRL_SSEL_LO    0
`define CTRL_DIV_LO     2
`define CTRL_MODE_LO    4
`define CTRL_CLEAR      6
`define CTRL_RESET      7'h00
// Counter modes
`define MODE_STOP       2'h0
`define MODE_UP         2'h1
`define MODE_CONT       2'h2
`define MODE_UPDOWN     2'h3
// ****************************************
// Channel control fields
// ****************************************
`define CCTL_CAP        0
`define CCTL_EDGE_LO    1
`define CCTL_INSEL_LO   3
`define CCTL_SWCAP      5
`define CCTL_OMODE_LO   6
`define CCTL_OUTVAL     9
`define CCTL_RESET      10'h000
// ****************************************
// Interrupt status bits
// ****************************************
`define IRQ_OVF         0
`define IRQ_CH0         1
`define IRQ_RESET       6'h00
`endif

// file: design/capture_compare_timer16.v
// 16-bit timer with five capture/compare channels behind an APB slave
//
// Notes on behaviour
// - Source select 0 pin, 1 aux, 2/3 main.
// - Selected clock divided by 1, 2, 4, 8.
// - One 16-bit counter shared by five channels.
// - Software halts, reads and writes the counter.
// - Stop mode and continuous counting mode.
// - Up and up/down modes, channel 0 period.
// - Each channel capture or compare by software.
// - Capture on rising, falling or both edges.
// - Capture input: 0 pin, 1 aux, 2/3 software.
// - Captures still work with counter clock stopped.
// - Each channel has its own output unit.
// - Channel 0 own interrupt, others shared one.
// - Vector word names pending shared event.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_timer16_regs.vh"

module capture_compare_timer16 (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Asynchronous pins
  input  wire        ext_timer_clk_in,
  input  wire        aux_clk,
  input  wire [4:0]  cap_ext,
  // Channel outputs
  output reg  [4:0]  cc_out,
  // Interrupts
  output reg         irq,
  output reg         irq_ch0,
  output reg         irq_shared
);

  // ****************************************
  // Storage
  // ****************************************
  reg  [6:0]  ctrl;              // Source, divider, mode
  reg  [15:0] cnt;               // Shared counter
  reg         dir_down;          // Up/down direction
  reg  [2:0]  divcnt;            // Prescaler count
  reg  [5:0]  status;            // Sticky event flags
  reg  [5:0]  mask;              // Interrupt enables
  reg  [15:0] ccr [0:4];         // Capture/compare values
  reg  [9:0]  cctl [0:4];        // Channel controls
  reg  [4:0]  swprev;            // Last software capture level
  reg  [6:0]  s1;                // Synchroniser stage one
  reg  [6:0]  s2;                // Synchroniser stage two
  reg  [6:0]  s3;                // Synchroniser stage three
  reg  [6:0]  acc;               // Accepted input levels

  // ****************************************
  // Input synchronisers
  // ****************************************
  wire [6:0] raw_in = {aux_clk, ext_timer_clk_in, cap_ext};
  wire [6:0] stable = ~(s2 ^ s3);          // Stages two and three agree
  wire [6:0] rise   = stable & s2 & ~acc;
  wire [6:0] fall   = stable & ~s2 & acc;

  // Three stages; only stage two reads stage one
  always @(posedge clk_sys) begin
    if (rst) begin
      s1  <= 7'h00;
      s2  <= 7'h00;
      s3  <= 7'h00;
      acc <= 7'h00;
    end else begin
      s1  <= raw_in;
      s2  <= s1;
      s3  <= s2;
      acc <= (acc & ~stable) | (s2 & stable);
    end
  end

  // ****************************************
  // APB decode
  // ****************************************
  wire       acc_done = psel & penable & pready;  // Completing edge
  wire       wr       = acc_done & pwrite;
  wire       rd       = psel & penable & ~pready & ~pwrite; // Taken edge
  wire [2:0] chidx    = paddr[4:2];
  wire       in_cctl  = ({paddr[7:5], paddr[1:0]} == 5'h04) & (chidx < 3'h5);
  wire       in_ccr   = ({paddr[7:5], paddr[1:0]} == 5'h08) & (chidx < 3'h5);
  wire       mapped   = (paddr == `OFS_CTRL) | (paddr == `OFS_COUNT) |
                        (paddr == `OFS_IRQ_STATUS) |
                        (paddr == `OFS_IRQ_MASK) |
                        (paddr == `OFS_VECTOR) |
                        in_cctl | in_ccr;

  // ****************************************
  // Clock select and prescaler
  // ****************************************
  wire [1:0] ssel = ctrl[`CTRL_SSEL_LO+1:`CTRL_SSEL_LO];
  wire [1:0] div  = ctrl[`CTRL_DIV_LO+1:`CTRL_DIV_LO];
  wire [1:0] mode = ctrl[`CTRL_MODE_LO+1:`CTRL_MODE_LO];
  reg        src_tick;
  reg  [2:0] divmask;

  // Source edge and divide ratio
  always @* begin
    case (ssel)
      2'h0:    src_tick = rise[5];             // Timer clock pin
      2'h1:    src_tick = rise[6];             // Auxiliary clock
      default: src_tick = 1'b1;                // Main clock
    endcase
    case (div)
      2'h0:    divmask = 3'h0;                 // By one
      2'h1:    divmask = 3'h1;                 // By two
      2'h2:    divmask = 3'h3;                 // By four
      default: divmask = 3'h7;                 // By eight
    endcase
  end

  // Counter advances only while a counting mode runs
  wire tick = src_tick & (divcnt == divmask) & (mode != `MODE_STOP);

  // ****************************************
  // Counter next value
  // ****************************************
  reg [15:0] next_cnt;
  reg        next_down;
  reg        ovf;

  // Period set by channel 0 in up and up/down
  always @* begin
    next_cnt  = cnt + 16'h0001;
    next_down = dir_down;
    ovf       = 1'b0;
    case (mode)
      `MODE_UP: begin
        if (cnt >= ccr[0]) begin               // Restart at zero
          next_cnt = 16'h0000;
          ovf      = 1'b1;
        end
      end
      `MODE_CONT: begin
        ovf = (cnt == 16'hffff);               // Full range wrap
      end
      `MODE_UPDOWN: begin
        if (!dir_down) begin
          if (cnt >= ccr[0]) begin             // Turn back at peak
            next_down = 1'b1;
            next_cnt  = (cnt == 16'h0000) ? 16'h0000 : cnt - 16'h0001;
          end
        end else if (cnt <= 16'h0001) begin    // Reaches zero
          next_cnt  = 16'h0000;
          next_down = 1'b0;
          ovf       = 1'b1;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      default: begin                           // Stopped: hold
        next_cnt = cnt;
      end
    endcase
  end

  wire clr_cmd = wr & (paddr == `OFS_CTRL) & pwdata[`CTRL_CLEAR];

  // Counter, direction and prescaler
  always @(posedge clk_sys) begin
    if (rst || clr_cmd) begin
      cnt      <= 16'h0000;
      dir_down <= 1'b0;
      divcnt   <= 3'h0;
    end else if (wr && paddr == `OFS_COUNT) begin
      cnt <= pwdata[15:0];                     // Software load
    end else begin
      if (src_tick && mode != `MODE_STOP) begin
        divcnt <= (divcnt == divmask) ? 3'h0 : divcnt + 3'h1;
      end
      if (tick) begin
        cnt      <= next_cnt;                  // Single shared count
        dir_down <= next_down;
      end
    end
  end

  // Control register; clear bit is a pulse, not stored
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
    end else if (wr && paddr == `OFS_CTRL) begin
      ctrl <= {1'b0, pwdata[5:0]};             // Halt via mode 0
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  wire [4:0] ch_set;                           // Channel event pulses
  wire [4:0] hit;                              // Compare matches
  wire [4:0] next_out;                         // Output unit results

  genvar n;
  generate
    for (n = 0; n < 5; n = n + 1) begin : g_ch
      wire       capm  = cctl[n][`CCTL_CAP];   // Capture or compare
      wire [1:0] edg   = cctl[n][`CCTL_EDGE_LO+1:`CCTL_EDGE_LO];
      wire [1:0] isel  = cctl[n][`CCTL_INSEL_LO+1:`CCTL_INSEL_LO];
      wire [2:0] omode = cctl[n][`CCTL_OMODE_LO+2:`CCTL_OMODE_LO];
      wire       swl   = cctl[n][`CCTL_SWCAP];
      reg        c_r;
      reg        c_f;
      reg        o;

      // Capture source select
      always @* begin
        case (isel)
          2'h0: begin
            c_r = rise[n];
            c_f = fall[n];
          end
          2'h1: begin
            c_r = rise[6];
            c_f = fall[6];
          end
          default: begin                       // Software driven level
            c_r = swl & ~swprev[n];
            c_f = ~swl & swprev[n];
          end
        endcase
      end

      // Edge choice; counter need not run to capture
      wire cap = capm & ((edg[0] & c_r) | (edg[1] & c_f));
      assign hit[n]    = ~capm & tick & (next_cnt == ccr[n]);
      assign ch_set[n] = cap | hit[n];

      // Output unit: match and period events steer the pin
      always @* begin
        case (omode)
          3'h0: o = cctl[n][`CCTL_OUTVAL];     // Independent of compare
          3'h1: o = hit[n] ? 1'b1 : cc_out[n];
          3'h2: o = hit[0] ? 1'b0 : (hit[n] ? ~cc_out[n] : cc_out[n]);
          3'h3: o = hit[0] ? 1'b0 : (hit[n] ? 1'b1 : cc_out[n]);
          3'h4: o = hit[n] ? ~cc_out[n] : cc_out[n];
          3'h5: o = hit[n] ? 1'b0 : cc_out[n];
          3'h6: o = hit[0] ? 1'b1 : (hit[n] ? ~cc_out[n] : cc_out[n]);
          default: o = hit[0] ? 1'b1 : (hit[n] ? 1'b0 : cc_out[n]);
        endcase
      end
      assign next_out[n] = o;

      // Channel registers; capture takes priority over a software write
      always @(posedge clk_sys) begin
        if (rst) begin
          ccr[n]    <= 16'h0000;
          cctl[n]   <= `CCTL_RESET;
          swprev[n] <= 1'b0;
        end else begin
          swprev[n] <= swl;
          if (wr && in_ccr && chidx == n) begin
            ccr[n] <= pwdata[15:0];
          end
          if (cap) begin
            ccr[n] <= cnt;                     // Latch count
          end
          if (wr && in_cctl && chidx == n) begin
            cctl[n] <= pwdata[9:0];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Interrupts and vector word
  // ****************************************
  wire [5:0] set_vec = {ch_set, tick & ovf};
  wire [5:0] pend    = status & mask;
  reg  [15:0] vec;
  reg  [5:0]  vclr;

  // Shared events by priority, ch1 first, overflow last
  always @* begin
    vec  = 16'h0000;
    vclr = 6'h00;
    if (pend[2]) begin
      vec  = 16'h0002;
      vclr = 6'h04;
    end else if (pend[3]) begin
      vec  = 16'h0004;
      vclr = 6'h08;
    end else if (pend[4]) begin
      vec  = 16'h0006;
      vclr = 6'h10;
    end else if (pend[5]) begin
      vec  = 16'h0008;
      vclr = 6'h20;
    end else if (pend[0]) begin
      vec  = 16'h000a;
      vclr = 6'h01;
    end
  end

  wire [5:0] w1c  = (wr && paddr == `OFS_IRQ_STATUS) ? pwdata[5:0] : 6'h00;
  wire [5:0] rclr = (rd && paddr == `OFS_VECTOR) ? vclr : 6'h00;

  // Sticky flags; a new event wins over any clear
  always @(posedge clk_sys) begin
    if (rst) begin
      status <= `IRQ_RESET;
      mask   <= `IRQ_RESET;
    end else begin
      status <= (status & ~w1c & ~rclr) | set_vec;
      if (wr && paddr == `OFS_IRQ_MASK) begin
        mask <= pwdata[5:0];
      end
    end
  end

  // ****************************************
  // Registered outputs and APB answer
  // ****************************************
  reg [31:0] rdata;

  // Read mux
  always @* begin
    rdata = 32'h0000_0000;
    if (in_cctl) begin
      rdata = {22'h000000, cctl[chidx]};
    end else if (in_ccr) begin
      rdata = {16'h0000, ccr[chidx]};
    end else begin
      case (paddr)
        `OFS_CTRL:       rdata = {25'h0000000, ctrl};
        `OFS_COUNT:      rdata = {16'h0000, cnt};   // Live count
        `OFS_IRQ_STATUS: rdata = {26'h0000000, status};
        `OFS_IRQ_MASK:   rdata = {26'h0000000, mask};
        `OFS_VECTOR:     rdata = {16'h0000, vec};
        default:         rdata = 32'h0000_0000;
      endcase
    end
  end

  // One wait state, so every bus output comes from a flop
  always @(posedge clk_sys) begin
    if (rst) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
      cc_out     <= 5'h00;
      irq        <= 1'b0;
      irq_ch0    <= 1'b0;
      irq_shared <= 1'b0;
    end else begin
      pready     <= psel & penable & ~pready;
      pslverr    <= psel & penable & ~pready & ~mapped;
      prdata     <= (psel & penable & ~pready) ? rdata : 32'h0000_0000;
      cc_out     <= next_out;
      irq        <= |pend;
      irq_ch0    <= pend[`IRQ_CH0];            // Own vector
      irq_shared <= |(pend & 6'h3d);           // Shared vector
    end
  end

endmodule
`default_nettype wire

// file: dv/timer16_checker_sva.sv
// Assertions on the timer's bus and interrupt pins
`timescale 1ns/1ps
`default_nettype none
module timer16_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Outputs
  input wire logic [4:0]  cc_out,
  input wire logic        irq,
  input wire logic        irq_ch0,
  input wire logic        irq_shared
);
  // One domain only, so one clock and one disable
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_answer;
    psel && penable && !$past(penable) |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("late ready");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_cause;
    pready |-> $past(psel && penable);
  endproperty
  a_cause: assert property (p_cause) else $error("stray ready");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("stale data");
  property p_unmapped;
    psel && penable && !$past(penable) && paddr == 8'hfc |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_mapped;
    psel && penable && !$past(penable) && paddr == 8'h04 |=> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("false error");
  property p_split;
    irq == (irq_ch0 || irq_shared);
  endproperty
  a_split: assert property (p_split) else $error("irq split");
  property p_quiet;
    $past(rst) |-> !irq && !pready && cc_out == 5'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reset state");
endmodule
bind capture_compare_timer16 timer16_checker chk_u (.clk_sys, .rst,
  .psel, .penable, .paddr, .prdata, .pready, .pslverr, .cc_out, .irq,
  .irq_ch0, .irq_shared);
`default_nettype wire

// file: dv/apb_host_model.sv
// Bus master standing in for the processor core
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  // Clock
  input  wire logic        clk_sys,
  // Request
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  // Answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        hung
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // One transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Bounded, so a dead slave cannot hang the run
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    hung <= (n >= 16);
    // Idle edge keeps calls from reassigning in one step
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: dv/capture_compare_timer16_tb.sv
// Self-checking bench for the 16-bit capture/compare timer
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_timer16_regs.vh"
module capture_compare_timer16_tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        ext_timer_clk_in = 1'b0;
  logic        aux_clk = 1'b0;
  logic [4:0]  cap_ext = 5'h00;
  logic        psel, penable, pwrite, pready, pslverr, hung;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [4:0]  cc_out;
  logic        irq, irq_ch0, irq_shared;
  int          mismatches = 0;
  int          samples_checked = 0;
  capture_compare_timer16 dut_u (.clk_sys, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_timer_clk_in,
    .aux_clk, .cap_ext, .cc_out, .irq, .irq_ch0, .irq_shared);
  apb_host_model host_u (.clk_sys, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hung);
  // 200 MHz clock
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // A dead bus ends the run
  always @(posedge hung) begin
    mismatches++;
    finish_test();
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // Pin clock pulses, each held past the synchroniser
  task automatic pulse_ext(input int k);
    repeat (k) begin
      ext_timer_clk_in <= 1'b1;
      tick(6);
      ext_timer_clk_in <= 1'b0;
      tick(6);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    host_u.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a);
    logic e;
    host_u.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask
  // Reset values and an unmapped read
  task automatic s_reset();
    logic e;
    rd(`OFS_CTRL);
    chk(r, 32'h0);
    rd(`OFS_IRQ_MASK);
    chk(r, 32'h0);
    host_u.xfer(1'b0, 8'hfc, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask
  // Counter access, stop, dividers and wrap
  task automatic s_counter();
    wr(`OFS_COUNT, 32'h1234);
    tick(10);
    rd(`OFS_COUNT);
    chk(r, 32'h1234);
    for (int d = 0; d < 4; d++) begin
      wr(`OFS_CTRL, 32'h62 | (d << 2) | (d & 1));
      tick(64);
      wr(`OFS_CTRL, 32'h02);
      rd(`OFS_COUNT);
      chk_rng(r, 64 >> d, (72 >> d) + 1);
    end
    wr(`OFS_COUNT, 32'hfff0);
    wr(`OFS_CTRL, 32'h22);
    tick(40);
    wr(`OFS_CTRL, 32'h02);
    rd(`OFS_COUNT);
    chk_rng(r, 32'h14, 32'h24);
    rd(`OFS_IRQ_STATUS);
    chk(r & 32'h1, 32'h1);
  endtask
  // Pin and auxiliary clock sources
  task automatic s_source();
    wr(`OFS_CTRL, 32'h60);
    pulse_ext(4);
    rd(`OFS_COUNT);
    chk(r, 32'h4);
    wr(`OFS_CTRL, 32'h61);
    for (int i = 0; i < 3; i++) begin
      aux_clk <= 1'b1;
      tick(6);
      aux_clk <= 1'b0;
      tick(6);
    end
    rd(`OFS_COUNT);
    chk(r, 32'h3);
  endtask
  // Captures with the counter stopped
  task automatic s_capture();
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_COUNT, 32'h0abc);
    wr(`OFS_CCTL_BASE, 32'h03);
    cap_ext <= 5'h01;
    tick(8);
    rd(`OFS_CCR_BASE);
    chk(r, 32'h0abc);
    wr(`OFS_COUNT, 32'h0bcd);
    wr(`OFS_CCTL_BASE + 8'h04, 32'h17);
    wr(`OFS_CCTL_BASE + 8'h04, 32'h37);
    rd(`OFS_CCR_BASE + 8'h04);
    chk(r, 32'h0bcd);
    wr(`OFS_COUNT, 32'h0cde);
    wr(`OFS_CCTL_BASE + 8'h08, 32'h0d);
    aux_clk <= 1'b1;
    tick(8);
    rd(`OFS_CCR_BASE + 8'h08);
    chk(r, 32'h0);
    aux_clk <= 1'b0;
    tick(8);
    rd(`OFS_CCR_BASE + 8'h08);
    chk(r, 32'h0cde);
    rd(`OFS_IRQ_STATUS);
    chk(r & 32'h0e, 32'h0e);
  endtask
  // Period, vector word, mask and clear
  task automatic s_period();
    wr(`OFS_CCTL_BASE, 32'h0);
    wr(`OFS_CCR_BASE, 32'h5);
    wr(`OFS_IRQ_STATUS, 32'h3f);
    wr(`OFS_IRQ_MASK, 32'h03);
    for (int m = 1; m < 4; m += 2) begin
      wr(`OFS_CTRL, 32'h42 | (m << 4));
      for (int i = 0; i < 6; i++) begin
        rd(`OFS_COUNT);
        chk_rng(r, 0, 5);
      end
    end
    wr(`OFS_CTRL, 32'h02);
    tick(3);
    chk({irq, irq_ch0, irq_shared}, 32'h7);
    rd(`OFS_VECTOR);
    chk(r, 32'ha);
    rd(`OFS_VECTOR);
    chk(r, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h0);
    tick(3);
    chk(irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h02);
    tick(3);
    chk(irq, 1'b1);
    wr(`OFS_IRQ_STATUS, 32'h3f);
    tick(3);
    chk(irq, 1'b0);
  endtask
  // Fixed level and set-on-match outputs
  task automatic s_output();
    wr(`OFS_CCTL_BASE + 8'h0c, 32'h200);
    wr(`OFS_CCR_BASE + 8'h10, 32'h8);
    wr(`OFS_CCTL_BASE + 8'h10, 32'h40);
    tick(3);
    chk(cc_out, 32'h08);
    wr(`OFS_CTRL, 32'h62);
    tick(20);
    chk(cc_out[4:3], 32'h3);
  endtask
  // Shared vector order with channels 1 to 4 captured at once
  task automatic s_vector();
    wr(`OFS_CTRL, 32'h02);
    wr(`OFS_IRQ_STATUS, 32'h3f);
    wr(`OFS_IRQ_MASK, 32'h3d);
    for (int c = 1; c < 5; c++)
      wr(`OFS_CCTL_BASE + 8'(4 * c), 32'h03);
    cap_ext <= 5'h1f;
    tick(8);
    chk({irq_ch0, irq_shared}, 32'h1);
    for (int c = 1; c < 5; c++) begin
      rd(`OFS_VECTOR);
      chk(r, 2 * c);
    end
    rd(`OFS_VECTOR);
    chk(r, 32'h0);
    tick(3);
    chk(irq, 1'b0);
  endtask
  // Toggle output and turn-back, counted on single pin ticks
  task automatic s_updown();
    wr(`OFS_CCR_BASE + 8'h08, 32'h3);
    wr(`OFS_CCTL_BASE + 8'h08, 32'h100);
    wr(`OFS_CTRL, 32'h50);
    pulse_ext(3);
    chk(cc_out[2], 1'b1);
    pulse_ext(6);
    chk(cc_out[2], 1'b0);
    rd(`OFS_COUNT);
    chk(r, 32'h3);
    wr(`OFS_CTRL, 32'h70);
    pulse_ext(3);
    chk(cc_out[2], 1'b1);
    pulse_ext(4);
    chk(cc_out[2], 1'b0);
    rd(`OFS_COUNT);
    chk(r, 32'h3);
  endtask
  // Main sequence
  initial begin
    tick(6);
    rst <= 1'b0;
    tick(1);
    s_reset();
    s_counter();
    s_source();
    s_capture();
    s_period();
    s_output();
    s_vector();
    s_updown();
    finish_test();
  end
endmodule
`default_nettype wire
